// >>> hw/t2c_timer.sv
// 8-bit timer/counter with two compare channels, prescaler, flags and
// interrupt requests, behind an Avalon-MM slave with waitrequest.
// Assumes the timer source clock is slower than a quarter of i_clk_sys.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.

// Summary of operation
// - Force strobes act only in non-PWM modes
// - Force strobe applies compare action to pin
// - Forced compare sets no flag, no clear
// - Force bits are write-only, read zero
// - Control B bits 5:4 read zero
// - Clock select: stop, direct, prescaled divides
// - Counter register is readable and writable
// - Counter write blocks next tick's match
// - Both compare registers compared with counter
// - Interrupt needs enable, global bit, flag
// - Compare match sets its channel flag
// - Vector acknowledge clears its flag
// - Writing one clears a flag
// - Overflow flag; phase-correct sets at bottom
// - Wave mode decode selects TOP and sequence
// - Output mode: off, toggle, clear, set
module t2c_timer
    import t2c_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire logic i_timer_source_clock,
    input wire t2c_avs_req_type i_avs_req,
    input wire logic i_global_irq_en,
    input wire logic [2:0] i_irq_ack,
    output logic o_avs_waitrequest,
    output logic [31:0] o_avs_readdata,
    output logic o_wave_out_a,
    output logic o_wave_out_b,
    output logic [1:0] o_wave_en,
    output logic [2:0] o_irq
);

    t2c_state_type st_ff;
    t2c_state_type nxt_st;
    t2c_mode_type mode;
    logic pwm;
    logic pc;
    logic fast;
    logic [7:0] top;
    logic src_rise;
    logic tick;
    logic match_a;
    logic match_b;
    logic at_top;
    logic top_evt;
    logic [2:0] set_flags;
    logic [2:0] clr_flags;
    logic [1:0] frc;
    logic wr_en;
    logic rd_cap;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [9:0] presc_mask(input logic [2:0] sel);
        case (t2c_clk_sel_type'(sel))
            T2C_CS_DIV8: presc_mask = T2C_PRE_MASK_8;
            T2C_CS_DIV32: presc_mask = T2C_PRE_MASK_32;
            T2C_CS_DIV64: presc_mask = T2C_PRE_MASK_64;
            T2C_CS_DIV128: presc_mask = T2C_PRE_MASK_128;
            T2C_CS_DIV256: presc_mask = T2C_PRE_MASK_256;
            T2C_CS_DIV1024: presc_mask = T2C_PRE_MASK_1024;
            default: presc_mask = 10'h000;
        endcase
    endfunction

    // One channel's pin update; inv flips the action while counting down
    function automatic logic wave_next(input logic cur, input logic [1:0] com,
        input logic ev, input logic inv, input logic tog_ok, input logic top_ev);
        logic r;
        r = cur;
        if (ev)
        begin
            if (com == T2C_COM_TOGGLE)
            begin
                r = tog_ok ? ~cur : cur;
            end
            else if (com[1])
            begin
                r = com[0] ^ inv;
            end
        end
        if (top_ev && com[1])
        begin
            r = ~com[0];
        end
        wave_next = r;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        mode = t2c_mode_type'({st_ff.wgm_hi, st_ff.ctrl_a[1:0]});
        pwm = mode[0];
        pc = (mode[1:0] == 2'b01);
        fast = (mode[1:0] == 2'b11);
        // Reserved modes 4 and 6 fall back to a free up-count to 0xff
        top = (mode == T2C_M_CTC || mode == T2C_M_PC_CMPA || mode == T2C_M_FAST_CMPA)
            ? st_ff.cmp_a : T2C_MAX;

        // Source clock: only the second and third stages are compared
        nxt_st.src_sync = {st_ff.src_sync[1:0], i_timer_source_clock};
        src_rise = 1'b0;
        if (st_ff.src_sync[1] == st_ff.src_sync[2] && st_ff.src_sync[2] != st_ff.src_lvl)
        begin
            nxt_st.src_lvl = st_ff.src_sync[2];
            src_rise = st_ff.src_sync[2];
        end
        if (src_rise)
        begin
            nxt_st.presc = st_ff.presc + 10'h001;
        end
        // Prescaler runs free, so the first tick after a select may come early
        tick = src_rise && (st_ff.clk_sel == T2C_CS_DIV1
            || (st_ff.clk_sel != T2C_CS_STOP
            && (st_ff.presc & presc_mask(st_ff.clk_sel)) == presc_mask(st_ff.clk_sel)));

        match_a = (st_ff.count == st_ff.cmp_a) && !st_ff.block;
        match_b = (st_ff.count == st_ff.cmp_b) && !st_ff.block;
        at_top = (st_ff.count == top);
        set_flags = 3'b000;
        top_evt = 1'b0;

        // ------------------------------------------------------------
        // Counting sequence
        // ------------------------------------------------------------
        if (tick)
        begin
            nxt_st.block = 1'b0;
            set_flags[T2C_CMPA_BIT] = match_a;
            set_flags[T2C_CMPB_BIT] = match_b;
            if (pc)
            begin
                if (!st_ff.down)
                begin
                    if (at_top)
                    begin
                        nxt_st.down = 1'b1;
                        nxt_st.count = st_ff.count - 8'h01;
                    end
                    else
                    begin
                        nxt_st.count = st_ff.count + 8'h01;
                    end
                end
                else if (st_ff.count == T2C_BOTTOM)
                begin
                    nxt_st.down = 1'b0;
                    nxt_st.count = st_ff.count + 8'h01;
                    set_flags[T2C_OVF_BIT] = 1'b1;
                end
                else
                begin
                    nxt_st.count = st_ff.count - 8'h01;
                end
            end
            else
            begin
                nxt_st.down = 1'b0;
                nxt_st.count = at_top ? T2C_BOTTOM : st_ff.count + 8'h01;
                top_evt = fast && at_top;
                set_flags[T2C_OVF_BIT] = (mode == T2C_M_FAST_CMPA) ? at_top
                    : (st_ff.count == T2C_MAX);
            end
        end

        // ------------------------------------------------------------
        // Bus slave: one wait cycle, then a single answer cycle
        // ------------------------------------------------------------
        rd_cap = i_avs_req.read && st_ff.waitreq;
        wr_en = i_avs_req.write && !st_ff.waitreq && i_avs_req.byteenable[0];
        nxt_st.waitreq = !((i_avs_req.read || i_avs_req.write) && st_ff.waitreq);
        frc = 2'b00;
        clr_flags = i_irq_ack;
        if (rd_cap)
        begin
            nxt_st.rdata = 32'h0000_0000;
            case (i_avs_req.address)
                T2C_OFS_CTRL_A: nxt_st.rdata[7:0] = st_ff.ctrl_a;
                T2C_OFS_CTRL_B: nxt_st.rdata[7:0] = {4'h0, st_ff.wgm_hi, st_ff.clk_sel};
                T2C_OFS_COUNT: nxt_st.rdata[7:0] = st_ff.count;
                T2C_OFS_CMP_A: nxt_st.rdata[7:0] = st_ff.cmp_a;
                T2C_OFS_CMP_B: nxt_st.rdata[7:0] = st_ff.cmp_b;
                T2C_OFS_MASK: nxt_st.rdata[7:0] = {5'h00, st_ff.mask};
                T2C_OFS_FLAGS: nxt_st.rdata[7:0] = {5'h00, st_ff.flags};
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_en)
        begin
            case (i_avs_req.address)
                T2C_OFS_CTRL_A: nxt_st.ctrl_a = {i_avs_req.writedata[7:4], 2'b00,
                    i_avs_req.writedata[1:0]};
                T2C_OFS_CTRL_B:
                begin
                    nxt_st.wgm_hi = i_avs_req.writedata[T2C_WGM_HI_BIT];
                    nxt_st.clk_sel = i_avs_req.writedata[2:0];
                    if (!pwm)
                    begin
                        frc = {i_avs_req.writedata[T2C_FORCE_A_BIT],
                            i_avs_req.writedata[T2C_FORCE_B_BIT]};
                    end
                end
                T2C_OFS_COUNT:
                begin
                    nxt_st.count = i_avs_req.writedata[7:0];
                    nxt_st.block = 1'b1;
                end
                T2C_OFS_CMP_A: nxt_st.cmp_a = i_avs_req.writedata[7:0];
                T2C_OFS_CMP_B: nxt_st.cmp_b = i_avs_req.writedata[7:0];
                T2C_OFS_MASK: nxt_st.mask = i_avs_req.writedata[2:0];
                T2C_OFS_FLAGS: clr_flags = clr_flags | i_avs_req.writedata[2:0];
                default: nxt_st.mask = st_ff.mask;
            endcase
        end

        // A set in the same cycle as a clear wins; forces never set flags
        nxt_st.flags = (st_ff.flags & ~clr_flags) | set_flags;
        nxt_st.irq = nxt_st.flags & nxt_st.mask & {3{i_global_irq_en}};

        // ------------------------------------------------------------
        // Waveform outputs
        // ------------------------------------------------------------
        // Compare equal to TOP with set/clear mode is left to the TOP action in fast PWM; in phase-correct the pin holds
        nxt_st.wave[0] = wave_next(st_ff.wave[0], st_ff.ctrl_a[7:6],
            (tick && match_a && !(pwm && st_ff.ctrl_a[7] && st_ff.cmp_a == top)) || frc[1],
            pc && st_ff.down, !pwm || st_ff.wgm_hi, top_evt);
        nxt_st.wave[1] = wave_next(st_ff.wave[1], st_ff.ctrl_a[5:4],
            (tick && match_b && !(pwm && st_ff.ctrl_a[5] && st_ff.cmp_b == top)) || frc[0],
            pc && st_ff.down, !pwm, top_evt);
        nxt_st.wave_en = {nxt_st.ctrl_a[5:4] != T2C_COM_OFF,
            nxt_st.ctrl_a[7:6] != T2C_COM_OFF};
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_ff <= '0;
            st_ff.waitreq <= 1'b1;
        end
        else if (i_clk_en)
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_avs_waitrequest = st_ff.waitreq;
    assign o_avs_readdata = st_ff.rdata;
    assign o_wave_out_a = st_ff.wave[0];
    assign o_wave_out_b = st_ff.wave[1];
    assign o_wave_en = st_ff.wave_en;
    assign o_irq = st_ff.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    a_force_pwm_off:
        assert property (i_clk_en && wr_en && pwm && !tick
            && i_avs_req.address == T2C_OFS_CTRL_B |=> st_ff.wave == $past(st_ff.wave))
        else $error("force strobe acted in a PWM mode");
    a_force_toggle:
        assert property (i_clk_en && frc[1] && !tick && st_ff.ctrl_a[7:6] == T2C_COM_TOGGLE
            |=> st_ff.wave[0] != $past(st_ff.wave[0]))
        else $error("forced compare did not toggle pin a");
    a_force_no_flag:
        assert property (i_clk_en && frc != 2'b00 && !tick
            |=> (st_ff.flags & ~$past(st_ff.flags)) == 3'b000 && st_ff.count == $past(st_ff.count))
        else $error("forced compare set a flag or cleared the counter");
    a_ctlb_read_zero:
        assert property (i_clk_en && rd_cap && i_avs_req.address == T2C_OFS_CTRL_B
            |=> st_ff.rdata[7:4] == 4'h0 && st_ff.rdata[2:0] == $past(st_ff.clk_sel))
        else $error("control b read showed force or reserved bits");
    a_stop_holds:
        assert property (i_clk_en && st_ff.clk_sel == T2C_CS_STOP && !wr_en
            |=> st_ff.count == $past(st_ff.count))
        else $error("counter moved while stopped");
    a_count_write:
        assert property (i_clk_en && wr_en && i_avs_req.address == T2C_OFS_COUNT
            |=> st_ff.count == $past(i_avs_req.writedata[7:0]) && st_ff.block)
        else $error("counter write not taken");
    a_block_match:
        assert property (i_clk_en && tick && st_ff.block
            |=> (st_ff.flags[2:1] & ~$past(st_ff.flags[2:1])) == 2'b00)
        else $error("compare match not blocked after counter write");
    a_cmp_flag_set:
        assert property (i_clk_en && tick && !st_ff.block && st_ff.count == st_ff.cmp_a
            |=> st_ff.flags[T2C_CMPA_BIT])
        else $error("compare a match did not set its flag");
    a_irq_gate:
        assert property (i_clk_en |=> st_ff.irq
            == (st_ff.flags & st_ff.mask & {3{$past(i_global_irq_en)}}))
        else $error("interrupt request not gated by enable and flag");
    a_ack_clear:
        assert property (i_clk_en && i_irq_ack[0] && !set_flags[0] |=> !st_ff.flags[0])
        else $error("vector acknowledge did not clear the overflow flag");
    a_w1c_clear:
        assert property (i_clk_en && wr_en && i_avs_req.address == T2C_OFS_FLAGS
            && i_avs_req.writedata[1] && !set_flags[1] |=> !st_ff.flags[1])
        else $error("writing one did not clear compare a flag");
    a_pc_bottom_ovf:
        assert property (i_clk_en && tick && pc && st_ff.down && st_ff.count == T2C_BOTTOM
            |=> st_ff.flags[T2C_OVF_BIT] && !st_ff.down)
        else $error("phase-correct bottom did not set overflow");
    a_ctc_wrap:
        assert property (i_clk_en && tick && !wr_en && mode == T2C_M_CTC
            && st_ff.count == st_ff.cmp_a |=> st_ff.count == T2C_BOTTOM)
        else $error("ctc did not clear at compare a");
    a_bus_answer:
        assert property (i_clk_en && (i_avs_req.read || i_avs_req.write) && st_ff.waitreq
            |=> !st_ff.waitreq)
        else $error("bus answer not given one cycle after request");
    a_answer_once:
        assert property (i_clk_en && !st_ff.waitreq |=> st_ff.waitreq)
        else $error("bus answer stood longer than one cycle");
    a_ovf_at_max:
        assert property (i_clk_en && tick && !pc && mode != T2C_M_FAST_CMPA
            && st_ff.count == T2C_MAX |=> st_ff.flags[T2C_OVF_BIT])
        else $error("overflow flag not set at the top count");

    c_ovf_flag: cover property (tick && set_flags[0]);
    c_force_a: cover property (frc[1]);
    c_pc_reverse: cover property (tick && pc && st_ff.down && st_ff.count == T2C_BOTTOM);
    c_irq_raise: cover property (o_irq != 3'b000);
    c_count_block: cover property (tick && st_ff.block);

endmodule

// >>> hw/t2c_pkg.sv
// Package for the 8-bit timer block: register offsets, field positions,
// reset values, mode and clock-select encodings, bus and state carriers.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package t2c_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] T2C_OFS_CTRL_A = 5'h00;
    localparam logic [4:0] T2C_OFS_CTRL_B = 5'h04;
    localparam logic [4:0] T2C_OFS_COUNT = 5'h08;
    localparam logic [4:0] T2C_OFS_CMP_A = 5'h0c;
    localparam logic [4:0] T2C_OFS_CMP_B = 5'h10;
    localparam logic [4:0] T2C_OFS_MASK = 5'h14;
    localparam logic [4:0] T2C_OFS_FLAGS = 5'h18;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int T2C_FORCE_A_BIT = 7;
    localparam int T2C_FORCE_B_BIT = 6;
    localparam int T2C_WGM_HI_BIT = 3;
    localparam int T2C_OVF_BIT = 0;
    localparam int T2C_CMPA_BIT = 1;
    localparam int T2C_CMPB_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] T2C_REG_RESET = 8'h00;
    localparam logic [7:0] T2C_MAX = 8'hff;
    localparam logic [7:0] T2C_BOTTOM = 8'h00;
    localparam logic [9:0] T2C_PRE_MASK_8 = 10'h007;
    localparam logic [9:0] T2C_PRE_MASK_32 = 10'h01f;
    localparam logic [9:0] T2C_PRE_MASK_64 = 10'h03f;
    localparam logic [9:0] T2C_PRE_MASK_128 = 10'h07f;
    localparam logic [9:0] T2C_PRE_MASK_256 = 10'h0ff;
    localparam logic [9:0] T2C_PRE_MASK_1024 = 10'h3ff;

    typedef enum logic [2:0] {
        T2C_CS_STOP = 3'b000, T2C_CS_DIV1 = 3'b001, T2C_CS_DIV8 = 3'b010,
        T2C_CS_DIV32 = 3'b011, T2C_CS_DIV64 = 3'b100, T2C_CS_DIV128 = 3'b101,
        T2C_CS_DIV256 = 3'b110, T2C_CS_DIV1024 = 3'b111
    } t2c_clk_sel_type;

    typedef enum logic [2:0] {
        T2C_M_NORMAL = 3'b000, T2C_M_PC_FF = 3'b001, T2C_M_CTC = 3'b010,
        T2C_M_FAST_FF = 3'b011, T2C_M_RSV4 = 3'b100, T2C_M_PC_CMPA = 3'b101,
        T2C_M_RSV6 = 3'b110, T2C_M_FAST_CMPA = 3'b111
    } t2c_mode_type;

    typedef enum logic [1:0] {
        T2C_COM_OFF = 2'b00, T2C_COM_TOGGLE = 2'b01,
        T2C_COM_CLEAR = 2'b10, T2C_COM_SET = 2'b11
    } t2c_com_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } t2c_avs_req_type;

    typedef struct packed {
        logic [2:0] src_sync;
        logic src_lvl;
        logic [9:0] presc;
        logic [7:0] ctrl_a;
        logic wgm_hi;
        logic [2:0] clk_sel;
        logic [7:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [2:0] mask;
        logic [2:0] flags;
        logic down;
        logic block;
        logic [1:0] wave;
        logic [1:0] wave_en;
        logic [2:0] irq;
        logic waitreq;
        logic [31:0] rdata;
    } t2c_state_type;

endpackage

// >>> testbench/t2c_timer_tb_top.sv
// Self-checking bench for the timer block: bus tasks, timer source pulses and a
// monitor that compares queued notes with read data and pin samples.
// Assumes the design package and the t2c_timer module are compiled first.
module t2c_timer_tb_top
    import t2c_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, rstn, src_clk, global_en, probe, clk_en;
    logic [2:0] irq_ack;
    t2c_avs_req_type req;
    logic waitreq, wave_a, wave_b;
    logic [31:0] rdata;
    logic [1:0] wave_en;
    logic [2:0] irq;
    logic [63:0] rd_q[$];
    logic [13:0] pin_q[$];
    int bad_count, n_checks, seed;
    int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic [4:0] ofs[7] = '{T2C_OFS_CTRL_A, T2C_OFS_CTRL_B, T2C_OFS_COUNT, T2C_OFS_CMP_A,
        T2C_OFS_CMP_B, T2C_OFS_MASK, T2C_OFS_FLAGS};
    logic [7:0] codes[4] = '{8'h03, 8'h02, 8'h01, 8'h00};
    logic [7:0] r;

    t2c_timer t2c_timer_i (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_clk_en(clk_en),
        .i_timer_source_clock(src_clk), .i_avs_req(req), .i_global_irq_en(global_en),
        .i_irq_ack(irq_ack), .o_avs_waitrequest(waitreq), .o_avs_readdata(rdata),
        .o_wave_out_a(wave_a), .o_wave_out_b(wave_b), .o_wave_en(wave_en), .o_irq(irq));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Verdict and monitor
    // ----------------------------------------------------------------
    // Lets the monitor take the last answer before the notes are counted
    task automatic stop_test();
        repeat (2) @(posedge clk_sys);
        if (rd_q.size() != 0 || pin_q.size() != 0)
        begin
            $display("unexpected unchecked notes at %0t", $time);
            bad_count++;
        end
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        logic [63:0] nr;
        logic [13:0] np;
        if (req.read && waitreq === 1'b0 && rd_q.size() > 0)
        begin
            nr = rd_q.pop_front();
            n_checks++;
            if ((rdata & nr[63:32]) !== nr[31:0])
            begin
                $display("unexpected read data at %0t: got %h want %h", $time, rdata, nr[31:0]);
                bad_count++;
            end
        end
        if (probe && pin_q.size() > 0)
        begin
            np = pin_q.pop_front();
            n_checks++;
            if (({irq, wave_en, wave_b, wave_a} & np[13:7]) !== np[6:0])
            begin
                $display("unexpected pins at %0t: got %b want %b", $time,
                    {irq, wave_en, wave_b, wave_a}, np[6:0]);
                bad_count++;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------------------------------
    // A request starts one edge after the previous release, so no signal is set twice
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_sys);
        req <= '{read: !wr, write: wr, address: a, byteenable: 4'h1, writedata: {24'h0, d}};
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (waitreq !== 1'b0 && k < 20);
        req <= '0;
        if (k >= 20)
        begin
            $display("unexpected bus hang at %0t", $time);
            bad_count++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        rd_q.push_back({24'h0, m, 24'h0, e & m});
        bus(1'b0, a, 8'h00);
    endtask

    task automatic pins(input logic [6:0] e, input logic [6:0] m);
        @(posedge clk_sys);
        pin_q.push_back({m, e & m});
        probe <= 1'b1;
        @(posedge clk_sys);
        probe <= 1'b0;
    endtask

    // Each level lasts at least 4 system cycles, above the 2 the synchroniser needs
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            src_clk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            src_clk <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 46927;
        rstn = 1'b0;
        src_clk = 1'b0;
        global_en = 1'b0;
        clk_en = 1'b1;
        irq_ack = 3'h0;
        req = '0;
        probe = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 8'h00, 8'hff);
        wr(5'h1c, 8'hff);
        rd(5'h1c, 8'h00, 8'hff);
        rd(5'h05, 8'h00, 8'hff);
        wr(T2C_OFS_CTRL_B, 8'hff);
        rd(T2C_OFS_CTRL_B, 8'h0f, 8'hff);
        wr(T2C_OFS_CTRL_B, 8'h00);
        wr(T2C_OFS_MASK, 8'hff);
        rd(T2C_OFS_MASK, 8'h07, 8'hff);
        for (int i = 2; i < 5; i++)
        begin
            r = 8'($random(seed));
            wr(ofs[i], r);
            rd(ofs[i], r, 8'hff);
        end
        // Prescaler free runs, so 2*div source edges always give exactly two ticks
        for (int i = 0; i < 8; i++)
        begin
            wr(T2C_OFS_CTRL_B, 8'(i));
            wr(T2C_OFS_COUNT, 8'h00);
            pulse((i == 0) ? 5 : 2 * divs[i]);
            wr(T2C_OFS_CTRL_B, 8'h00);
            rd(T2C_OFS_COUNT, (i == 0) ? 8'h00 : 8'h02, 8'hff);
        end
        wr(T2C_OFS_FLAGS, 8'h07);
        wr(T2C_OFS_CTRL_A, 8'h00);
        wr(T2C_OFS_CMP_A, 8'h20);
        wr(T2C_OFS_CMP_B, 8'h22);
        global_en <= 1'b1;
        wr(T2C_OFS_COUNT, 8'h1e);
        wr(T2C_OFS_CTRL_B, 8'h01);
        pulse(6);
        rd(T2C_OFS_FLAGS, 8'h06, 8'h07);
        pins(7'h60, 7'h70);
        global_en <= 1'b0;
        pins(7'h00, 7'h70);
        global_en <= 1'b1;
        wr(T2C_OFS_MASK, 8'h02);
        pins(7'h20, 7'h70);
        wr(T2C_OFS_MASK, 8'h07);
        wr(T2C_OFS_FLAGS, 8'h02);
        rd(T2C_OFS_FLAGS, 8'h04, 8'h07);
        wr(T2C_OFS_FLAGS, 8'h00);
        rd(T2C_OFS_FLAGS, 8'h04, 8'h07);
        @(posedge clk_sys);
        irq_ack <= 3'h4;
        @(posedge clk_sys);
        irq_ack <= 3'h0;
        rd(T2C_OFS_FLAGS, 8'h00, 8'h07);
        wr(T2C_OFS_COUNT, 8'h20);
        pulse(1);
        rd(T2C_OFS_FLAGS, 8'h00, 8'h02);
        wr(T2C_OFS_FLAGS, 8'h07);
        wr(T2C_OFS_COUNT, 8'hfd);
        pulse(4);
        rd(T2C_OFS_FLAGS, 8'h01, 8'h01);
        wr(T2C_OFS_FLAGS, 8'h07);
        wr(T2C_OFS_CTRL_A, 8'h01);
        wr(T2C_OFS_COUNT, 8'h02);
        pulse(260);
        rd(T2C_OFS_FLAGS, 8'h00, 8'h01);
        pulse(260);
        rd(T2C_OFS_FLAGS, 8'h01, 8'h01);
        wr(T2C_OFS_CTRL_B, 8'h00);
        wr(T2C_OFS_CTRL_A, 8'h00);
        wr(T2C_OFS_FLAGS, 8'h07);
        // Counter stopped: pin a steps set, clear, toggle, then disconnects
        foreach (codes[i])
        begin
            wr(T2C_OFS_CTRL_A, {codes[i][1:0], 6'h00});
            wr(T2C_OFS_CTRL_B, 8'h80);
            pins({4'h0, (codes[i] != 8'h00), 1'b0, ~i[0]}, (codes[i] != 8'h00) ?
                7'h7d : 7'h7c);
        end
        rd(T2C_OFS_FLAGS, 8'h00, 8'h07);
        wr(T2C_OFS_CTRL_A, 8'h32);
        wr(T2C_OFS_COUNT, 8'h05);
        wr(T2C_OFS_CTRL_B, 8'hc0);
        pins(7'h0a, 7'h7e);
        rd(T2C_OFS_COUNT, 8'h05, 8'hff);
        wr(T2C_OFS_CTRL_A, 8'h23);
        // Breaks the software convention on purpose to show the strobe is ignored
        wr(T2C_OFS_CTRL_B, 8'h40);
        pins(7'h0a, 7'h7e);
        rd(T2C_OFS_FLAGS, 8'h00, 8'h07);
        // Running match toggles pin a and raises the compare a request
        wr(T2C_OFS_CTRL_A, 8'h40);
        wr(T2C_OFS_COUNT, 8'h1f);
        wr(T2C_OFS_CTRL_B, 8'h01);
        pulse(2);
        pins(7'h26, 7'h7f);
        // Source edges while frozen are lost, so the count must not move
        clk_en <= 1'b0;
        pulse(3);
        clk_en <= 1'b1;
        rd(T2C_OFS_COUNT, 8'h21, 8'hff);
        stop_test();
    end
endmodule
